//--- pkg/tsg_pkg.sv
// constants and types for the time-share gate generator
package tsg_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_NS         = 1_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHARE_US        = 250;
  localparam int unsigned BLANK_US        = 375;
  localparam int unsigned CURSOR_RISE_US  = 125;
  localparam int unsigned TICK_US         = TICK_NS / 1_000;
  localparam int unsigned SHARE_TICKS     = SHARE_US / TICK_US;
  localparam int unsigned BLANK_TICKS     = BLANK_US / TICK_US;
  localparam int unsigned RISE_TICKS      = CURSOR_RISE_US / TICK_US;
  localparam int unsigned IN_PPS          = 360;
  localparam int unsigned OUT_PPS         = 20;
  localparam int unsigned DIVIDE_NOMINAL  = IN_PPS / OUT_PPS;
  localparam int unsigned RATE_W          = 5;
  localparam int unsigned RAMP_W          = 10;
  localparam int unsigned CURSOR_W        = 8;
  localparam logic [RATE_W-1:0] RATE_NOMINAL = 5'h12;
  localparam logic [CURSOR_W-1:0] CURSOR_IDLE = 8'h00;
  localparam logic [CURSOR_W-1:0] CURSOR_TOP  = 8'hFF;
  localparam logic [CURSOR_W-1:0] CURSOR_STEP = 8'h40;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHARE = 2'b01,
    ST_TAIL  = 2'b10
  } gate_state_t;
endpackage

//--- verilog/tsg_tick.sv
// timebase divider producing a one-cycle tick enable
`timescale 1ns/1ps
`default_nettype none
module tsg_tick
  import tsg_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // timebase
  input  wire logic run,
  output var  logic tick
);
  logic [15:0] count;

  // restarts with each cycle so the first tick is exactly one period after start
  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (count == 16'(CYCLES - 1)) begin
      count <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule // tsg_tick
`default_nettype wire

//--- verilog/time_share_gate_generator.sv
// time-share gate, video blanking and cursor intensity generator
//
// Behaviour
// - leading (falling) edge of incoming negative gate becomes one trigger event
// - divide input triggers by eighteen, 360 pps in to 20 pps out
// - rate setting adjusts division; larger setting gives faster output rate
// - each output trigger starts time-share and blanking gates together
// - positive and complementary negative time-share gates last 250 us
// - time-share gate ends only at its ramp threshold
// - both time-share gates go to range and height sweep drivers
// - video blanking gate ends 375 us after its trigger
// - blanking ends 125 us after time-share gates end
// - one ramp ends both gates at thresholds in ratio 1 to 1.5
// - blanking suppresses video while cursor intensity output is supplied
// - cursor waveform and ramp start on blanking leading edge
// - cursor rises to upper limit at 125 us, holds until share end
// - at share end cursor steps to lower level until ramp ends
// - cursor waveform lasts 375 us and ends with blanking
// - at blanking end ramp resets at once, cursor returns to idle
`timescale 1ns/1ps
`default_nettype none
module time_share_gate_generator
  import tsg_pkg::*;
#(
  parameter int unsigned TICK_CLK     = TICK_CYCLES,
  parameter int unsigned SHARE_LIMIT  = SHARE_TICKS,
  parameter int unsigned RISE_LIMIT   = RISE_TICKS,
  parameter int unsigned DIVIDE_BASE  = 2 * DIVIDE_NOMINAL
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  // upstream gate, active low
  input  wire logic                radar_gate_n,
  // divider control
  input  wire logic [RATE_W-1:0]   output_rate_setting,
  // range sweep driver
  output var  logic                range_share_pos,
  output var  logic                range_share_neg,
  // height sweep driver
  output var  logic                height_share_pos,
  output var  logic                height_share_neg,
  // video amplifier
  output var  logic                video_blank,
  output var  logic [CURSOR_W-1:0] cursor_level,
  // status
  output var  logic                out_trigger
);
  // ramp thresholds: time-share at full count, blanking half as far again
  // so the two gate lengths keep their ratio whatever the tick period
  localparam logic [RAMP_W-1:0] SHARE_END = RAMP_W'(SHARE_LIMIT);
  localparam logic [RAMP_W-1:0] BLANK_END = RAMP_W'((SHARE_LIMIT * 3) / 2);
  localparam logic [RAMP_W-1:0] RISE_END  = RAMP_W'(RISE_LIMIT);
  localparam logic [RATE_W:0]   SPAN_MIN  = (RATE_W+1)'(1);
  localparam logic [RATE_W:0]   COUNT_ONE = (RATE_W+1)'(1);
  localparam logic [RAMP_W-1:0] RAMP_ONE  = RAMP_W'(1);

  gate_state_t         state;
  gate_state_t         next_state;
  logic                gate_prev;
  logic                gate_fall;
  logic                in_trigger;
  logic [RATE_W:0]     divide_count;
  logic [RATE_W:0]     next_divide_count;
  logic [RATE_W:0]     divide_span;
  logic                div_hit;
  logic                fire;
  logic                accepted;
  logic [RAMP_W-1:0]   ramp;
  logic [RAMP_W-1:0]   next_ramp;
  logic [RAMP_W-1:0]   ramp_ahead;
  logic                tick;
  logic                share_done;
  logic                blank_done;
  logic                share_gate;
  logic                blank_gate;
  logic [CURSOR_W-1:0] next_cursor;

  // the divider span shrinks as the setting rises, so output rate climbs;
  // settings at or past the base clamp to the shortest span
  function automatic logic [RATE_W:0] span_of(input logic [RATE_W-1:0] setting);
    logic [RATE_W+1:0] diff;
    diff = (RATE_W+2)'(DIVIDE_BASE) - {2'b00, setting};
    if (diff[RATE_W+1] || diff == '0) begin
      span_of = SPAN_MIN;
    end else begin
      span_of = diff[RATE_W:0];
    end
  endfunction

  // gate-cycle decodes shared by several outputs
  function automatic logic is_share(input gate_state_t st);
    is_share = (st == ST_SHARE);
  endfunction

  function automatic logic is_busy(input gate_state_t st);
    is_busy = (st != ST_IDLE);
  endfunction

  function automatic logic is_tail(input gate_state_t st);
    is_tail = (st == ST_TAIL);
  endfunction

  // rise scaled so the top is met at the rise threshold, clamped above it
  function automatic logic [CURSOR_W-1:0] rise_level(input logic [RAMP_W-1:0] count);
    logic [31:0] scaled;
    scaled = (32'(count) * 32'(CURSOR_TOP)) / RISE_LIMIT;
    if (count >= RISE_END || scaled > 32'(CURSOR_TOP)) begin
      rise_level = CURSOR_TOP;
    end else begin
      rise_level = CURSOR_W'(scaled);
    end
  endfunction

  // span registered so a setting change lands on a clean clock edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      divide_span <= span_of(RATE_NOMINAL);
    end else begin
      divide_span <= span_of(output_rate_setting);
    end
  end

  // idle level of the pin after reset, so reset release makes no false edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gate_prev <= 1'b1;
    end else begin
      gate_prev <= radar_gate_n;
    end
  end

  assign gate_fall = gate_prev & ~radar_gate_n;

  // one trigger per falling edge of the incoming gate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      in_trigger <= 1'b0;
    end else begin
      in_trigger <= gate_fall;
    end
  end

  // terminal count of the divider on this input trigger
  always_comb begin
    div_hit           = 1'b0;
    next_divide_count = divide_count;
    if (in_trigger) begin
      if (divide_count + COUNT_ONE >= divide_span) begin
        div_hit           = 1'b1;
        next_divide_count = '0;
      end else begin
        next_divide_count = divide_count + COUNT_ONE;
      end
    end
  end

  // keeps counting during a gate cycle so the output phase stays
  // locked to the input train; refused fires still restart the count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      divide_count <= '0;
    end else begin
      divide_count <= next_divide_count;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fire <= 1'b0;
    end else begin
      fire <= div_hit;
    end
  end

  // a fire only starts a cycle while no gate cycle is running
  assign accepted = fire && !is_busy(state);

  // timebase runs only inside a gate cycle, so each cycle starts on a clean
  // phase; the first tick lands one full period after the trigger
  tsg_tick #(
    .CYCLES (TICK_CLK)
  ) tsg_tick_i (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (is_busy(state)),
    .tick     (tick)
  );

  assign ramp_ahead = ramp + RAMP_ONE;

  // the shared ramp, counted in timebase ticks; it clears in the cycle
  // blanking ends, so a following cycle always starts from zero
  always_comb begin
    next_ramp = ramp;
    if (state == ST_IDLE || blank_done) begin
      next_ramp = '0;
    end else if (tick) begin
      next_ramp = ramp_ahead;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ramp <= '0;
    end else begin
      ramp <= next_ramp;
    end
  end

  // both gates end where the one ramp crosses their thresholds
  always_comb begin
    share_done = 1'b0;
    blank_done = 1'b0;
    if (tick) begin
      share_done = (ramp_ahead == SHARE_END);
      blank_done = (ramp_ahead == BLANK_END);
    end
  end

  // only the ramp thresholds end a gate; triggers seen mid-cycle
  // never reach this logic
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (accepted) begin
          next_state = ST_SHARE;
        end
      end
      ST_SHARE: begin
        if (share_done) begin
          next_state = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (blank_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // fires arriving outside idle are dropped by the accepted gate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // gate levels for the cycle about to start, shared by the output flops
  always_comb begin
    share_gate = is_share(next_state);
    blank_gate = is_busy(next_state);
  end

  // range sweep driver, positive gate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      range_share_pos <= 1'b0;
    end else begin
      range_share_pos <= share_gate;
    end
  end

  // range sweep driver, complementary gate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      range_share_neg <= 1'b1;
    end else begin
      range_share_neg <= !share_gate;
    end
  end

  // height sweep driver, positive gate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      height_share_pos <= 1'b0;
    end else begin
      height_share_pos <= share_gate;
    end
  end

  // height sweep driver, complementary gate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      height_share_neg <= 1'b1;
    end else begin
      height_share_neg <= !share_gate;
    end
  end

  // blanking gate to video amplifier
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      video_blank <= 1'b0;
    end else begin
      video_blank <= blank_gate;
    end
  end

  // cursor intensity: linear rise, clamp at top, step down at share end
  always_comb begin
    next_cursor = cursor_level;
    if (next_state == ST_IDLE) begin
      next_cursor = CURSOR_IDLE;
    end else if (is_tail(next_state)) begin
      next_cursor = CURSOR_STEP;
    end else if (state == ST_IDLE) begin
      next_cursor = CURSOR_IDLE;
    end else if (tick) begin
      next_cursor = rise_level(ramp_ahead);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cursor_level <= CURSOR_IDLE;
    end else begin
      cursor_level <= next_cursor;
    end
  end

  // status pulse only for a divided trigger that starts a gate cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_trigger <= 1'b0;
    end else begin
      out_trigger <= accepted;
    end
  end
endmodule // time_share_gate_generator
`default_nettype wire

//--- sim/tsg_monitor.sv
// concurrent checks on the time-share gate generator ports
`timescale 1ns/1ps
`default_nettype none
module tsg_monitor
  import tsg_pkg::*;
#(
  parameter int unsigned TICK_CLK    = TICK_CYCLES,
  parameter int unsigned SHARE_LIMIT = SHARE_TICKS,
  parameter int unsigned RISE_LIMIT  = RISE_TICKS
) (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                sys_rst,
  // watched outputs
  input wire logic                range_share_pos,
  input wire logic                range_share_neg,
  input wire logic                height_share_pos,
  input wire logic                height_share_neg,
  input wire logic                video_blank,
  input wire logic [CURSOR_W-1:0] cursor_level,
  input wire logic                out_trigger
);
  localparam int SH = SHARE_LIMIT * TICK_CLK;
  localparam int BL = SH * 3 / 2;
  localparam int RT = RISE_LIMIT * TICK_CLK;
  logic [15:0] cnt;
  // cycles of blanking so far; stale in the trigger cycle itself
  always_ff @(posedge core_clk) begin
    if (sys_rst) cnt <= '0;
    else if (out_trigger) cnt <= 16'h0001;
    else if (video_blank) cnt <= cnt + 16'h0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_share_complement: assert property (range_share_neg == !range_share_pos) else $error("share not complementary");
  a_height_copy: assert property (height_share_pos == range_share_pos && height_share_neg == range_share_neg)
    else $error("height gates differ");
  a_start_together: assert property ($rose(range_share_pos) |-> $rose(video_blank) && out_trigger)
    else $error("gates did not start together");
  a_share_length: assert property ($fell(range_share_pos) |-> video_blank && cnt inside {[SH-1:SH+1]})
    else $error("share gate length wrong");
  a_blank_length: assert property ($fell(video_blank) |-> cnt inside {[BL-1:BL+1]}) else $error("blank length wrong");
  a_cursor_idle: assert property (!video_blank |-> cursor_level == CURSOR_IDLE) else $error("cursor not idle");
  a_cursor_step: assert property (video_blank && !range_share_pos |-> cursor_level == CURSOR_STEP)
    else $error("cursor step wrong");
  a_cursor_top: assert property (range_share_pos && !out_trigger && cnt > RT + 2 |-> cursor_level == CURSOR_TOP)
    else $error("cursor not at top");
  a_trigger_pulse: assert property (out_trigger |=> !out_trigger) else $error("trigger too long");
  a_no_retrigger: assert property ($past(video_blank) && video_blank |-> !out_trigger) else $error("retriggered");
endmodule // tsg_monitor
bind time_share_gate_generator tsg_monitor #(.TICK_CLK(TICK_CLK), .SHARE_LIMIT(SHARE_LIMIT), .RISE_LIMIT(RISE_LIMIT))
  tsg_monitor_i (.core_clk(core_clk), .sys_rst(sys_rst), .range_share_pos(range_share_pos),
  .range_share_neg(range_share_neg), .height_share_pos(height_share_pos), .height_share_neg(height_share_neg),
  .video_blank(video_blank), .cursor_level(cursor_level), .out_trigger(out_trigger));
`default_nettype wire

//--- sim/radar_gate_source.sv
// upstream gate generator model: trains of negative gates
`timescale 1ns/1ps
`default_nettype none
module radar_gate_source (
  // clock
  input wire logic       core_clk,
  // train request
  input wire logic       start,
  input wire logic [7:0] pulses,
  input wire logic [9:0] period,
  // gate out
  output var logic       radar_gate_n,
  output var logic       busy
);
  logic [7:0] left;
  logic [9:0] phase;
  initial begin
    radar_gate_n = 1'b1;
    busy = 1'b0;
  end
  always @(posedge core_clk) begin
    if (start) begin
      left <= pulses;
      phase <= '0;
      busy <= 1'b1;
    end else if (busy) begin
      // four cycles low per gate, idle high between
      radar_gate_n <= !(phase < 10'd4);
      phase <= (phase == period - 10'd1) ? '0 : phase + 10'd1;
      if (phase == period - 10'd1 && left == 8'd1) busy <= 1'b0;
      if (phase == period - 10'd1) left <= left - 8'd1;
    end else radar_gate_n <= 1'b1;
  end
endmodule // radar_gate_source
`default_nettype wire

//--- sim/time_share_gate_generator_tb.sv
// self-checking bench for the time-share gate generator
`timescale 1ns/1ps
`default_nettype none
module time_share_gate_generator_tb;
  import tsg_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, start = 1'b0, radar_gate_n, busy, out_trigger, video_blank;
  logic range_share_pos, range_share_neg, height_share_pos, height_share_neg;
  logic [4:0] output_rate_setting = 5'h12;
  logic [7:0] pulses = 8'h00, cursor_level;
  logic [9:0] period = 10'h018;
  logic [15:0] fired = '0, base, share_run = '0, blank_run = '0, last_share, last_blank;
  int failures = 0, samples_checked = 0;
  initial forever #10 core_clk = !core_clk;
  time_share_gate_generator #(.TICK_CLK(1)) time_share_gate_generator_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .radar_gate_n(radar_gate_n), .output_rate_setting(output_rate_setting), .range_share_pos(range_share_pos),
    .range_share_neg(range_share_neg), .height_share_pos(height_share_pos), .height_share_neg(height_share_neg),
    .video_blank(video_blank), .cursor_level(cursor_level), .out_trigger(out_trigger));
  radar_gate_source radar_gate_source_i (.core_clk(core_clk), .start(start), .pulses(pulses), .period(period),
    .radar_gate_n(radar_gate_n), .busy(busy));
  always @(posedge core_clk) begin
    if (!sys_rst && out_trigger) fired <= fired + 16'h0001;
    share_run <= range_share_pos ? share_run + 16'h0001 : '0;
    blank_run <= video_blank ? blank_run + 16'h0001 : '0;
    if (!range_share_pos && share_run != 0) last_share <= share_run;
    if (!video_blank && blank_run != 0) last_blank <= blank_run;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_range(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    cmp((got >= lo && got <= hi) ? got : 16'hFFFF, got);
  endtask
  // reset, then a gate train; waits until the train ends or hold cycles pass
  task automatic drive(input logic [4:0] rate, input logic [7:0] n, input logic [9:0] per, input int hold);
    int k;
    sys_rst <= 1'b1;
    output_rate_setting <= rate;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    base = fired;
    pulses <= n;
    period <= per;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    for (k = 0; k < hold && busy; k++) @(posedge core_clk);
  endtask
  task automatic test_divide;
    drive(5'h12, 8'd36, 10'd24, 5000);
    repeat (400) @(posedge core_clk);
    cmp(fired - base, 16'd2);
    cmp_range(last_share, 16'd249, 16'd251);
    cmp(last_blank, last_share + 16'd125);
    $display("test divide done");
  endtask
  task automatic test_rate;
    drive(5'h1A, 8'd20, 10'd40, 5000);
    repeat (400) @(posedge core_clk);
    cmp(fired - base, 16'd2);
    $display("test rate done");
  endtask
  task automatic test_refuse;
    drive(5'h1F, 8'd10, 10'd24, 5000);
    repeat (400) @(posedge core_clk);
    cmp(fired - base, 16'd1);
    $display("test refuse done");
  endtask
  task automatic test_abort;
    drive(5'h1F, 8'd9, 10'd24, 300);
    cmp({15'h0000, video_blank}, 16'h0001);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmp({5'h00, video_blank, range_share_pos, range_share_neg, cursor_level}, 16'h0100);
    drive(5'h1F, 8'd1, 10'd24, 100);
    repeat (50) @(posedge core_clk);
    cmp(fired - base, 16'd0);
    $display("test abort done");
  endtask
  task automatic give_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    test_divide();
    test_rate();
    test_refuse();
    test_abort();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    give_verdict();
  end
endmodule // time_share_gate_generator_tb
`default_nettype wire
